// file: rtl/tiu_pkg.sv
// package: constants and carriers for the trap and interrupt unit
package tiu_pkg;
  localparam int XLEN = 32;
  localparam int IRQ_W = 32;
  localparam int ID_W = 5;
  localparam int CAUSE_W = 5;
  // request line roles
  localparam logic [4:0] IRQ_SOFT = 5'h03;
  localparam logic [4:0] IRQ_TIMER = 5'h07;
  localparam logic [4:0] IRQ_EXT = 5'h0B;
  localparam logic [4:0] IRQ_CUST_HI = 5'h1F;
  localparam logic [4:0] IRQ_CUST_LO = 5'h10;
  // lines that may ever be enabled or pending
  localparam logic [31:0] IRQ_USED_MASK = 32'hFFFF_0888;
  // exception codes
  localparam logic [4:0] EXC_ILLEGAL = 5'h02;
  localparam logic [4:0] EXC_BREAK = 5'h03;
  localparam logic [4:0] EXC_ECALL = 5'h0B;
  // vector table alignment and vectoring
  localparam logic [31:0] VEC_BASE_MASK = 32'hFFFF_FF00;
  localparam logic [1:0] MODE_DIRECT = 2'h0;
  localparam logic [1:0] MODE_VECTORED = 2'h1;
  localparam int VEC_SHIFT = 2;
  // major opcodes (low seven bits)
  localparam logic [6:0] OP_LOAD = 7'h03;
  localparam logic [6:0] OP_LOAD_FP = 7'h07;
  localparam logic [6:0] OP_CUST0 = 7'h0B;
  localparam logic [6:0] OP_MISC_MEM = 7'h0F;
  localparam logic [6:0] OP_IMM = 7'h13;
  localparam logic [6:0] OP_AUIPC = 7'h17;
  localparam logic [6:0] OP_STORE = 7'h23;
  localparam logic [6:0] OP_STORE_FP = 7'h27;
  localparam logic [6:0] OP_CUST1 = 7'h2B;
  localparam logic [6:0] OP_OP = 7'h33;
  localparam logic [6:0] OP_LUI = 7'h37;
  localparam logic [6:0] OP_MADD = 7'h43;
  localparam logic [6:0] OP_MSUB = 7'h47;
  localparam logic [6:0] OP_NMSUB = 7'h4B;
  localparam logic [6:0] OP_NMADD = 7'h4F;
  localparam logic [6:0] OP_FP = 7'h53;
  localparam logic [6:0] OP_CUST2 = 7'h5B;
  localparam logic [6:0] OP_BRANCH = 7'h63;
  localparam logic [6:0] OP_JALR = 7'h67;
  localparam logic [6:0] OP_JAL = 7'h6F;
  localparam logic [6:0] OP_SYSTEM = 7'h73;
  localparam logic [6:0] OP_CUST3 = 7'h7B;
  // system funct12 codes
  localparam logic [11:0] F12_ECALL = 12'h000;
  localparam logic [11:0] F12_EBREAK = 12'h001;
  localparam logic [11:0] F12_MRET = 12'h302;
  // floating-point csr address range
  localparam logic [11:0] CSR_FP_LO = 12'h001;
  localparam logic [11:0] CSR_FP_HI = 12'h003;
  localparam logic [1:0] RVC_FULL = 2'h3;

  typedef struct packed {
    logic mie;
    logic mpie;
  } tiu_status_t;

  typedef struct packed {
    logic is_irq;
    logic [CAUSE_W-1:0] code;
  } tiu_cause_t;

  typedef struct packed {
    logic illegal;
    logic brk;
    logic ecall;
    logic mret;
  } tiu_decode_t;

  typedef struct packed {
    logic found;
    logic [ID_W-1:0] id;
  } tiu_pick_t;
endpackage : tiu_pkg

// file: rtl/tiu_irq_pick.sv
// fixed-priority selector over pending and enabled request lines
module tiu_irq_pick
  import tiu_pkg::*;
(
  input wire logic [IRQ_W-1:0] req,
  output tiu_pick_t pick
);
  logic [IRQ_W-1:0] cust_hit;
  // custom lines first, highest index wins
  generate
    for (genvar i = 0; i < IRQ_W; i++)
    begin : g_cust
      if (i >= IRQ_CUST_LO)
      begin : g_on
        assign cust_hit[i] = req[i];
      end
      else
      begin : g_off
        assign cust_hit[i] = 1'b0;
      end
    end
  endgenerate

  always_comb
  begin
    pick = '0;
    // scanning upward lets the last hit, the highest line, win
    for (int i = IRQ_CUST_LO; i < IRQ_W; i++)
    begin
      if (cust_hit[i])
      begin
        pick.found = 1'b1;
        pick.id = i[ID_W-1:0];
      end
    end
    if (!pick.found)
    begin
      if (req[IRQ_EXT])
      begin
        pick = '{found: 1'b1, id: IRQ_EXT};
      end
      else if (req[IRQ_SOFT])
      begin
        pick = '{found: 1'b1, id: IRQ_SOFT};
      end
      else if (req[IRQ_TIMER])
      begin
        pick = '{found: 1'b1, id: IRQ_TIMER};
      end
    end
  end
endmodule // tiu_irq_pick

// file: rtl/tiu_decode.sv
// classifies an instruction word into trap causes
module tiu_decode
  import tiu_pkg::*;
#(
  parameter bit float_unit_param = 1'b0,
  parameter bit custom_ext_param = 1'b0,
  parameter bit cluster_param = 1'b0
)
(
  input wire logic [XLEN-1:0] instr,
  output tiu_decode_t dec
);
  logic [6:0] opc;
  logic [2:0] f3;
  logic [11:0] f12;
  logic csr_fp;
  logic cust_ok;

  assign opc = instr[6:0];
  assign f3 = instr[14:12];
  assign f12 = instr[31:20];
  assign csr_fp = (f12 >= CSR_FP_LO) && (f12 <= CSR_FP_HI);
  assign cust_ok = custom_ext_param || cluster_param;

  // the base opcode map is judged here, plus funct3, funct12 and the float csr range for system words;
  // other field checks live in the main decoder
  always_comb
  begin
    dec = '0;
    if (instr[1:0] != RVC_FULL)
    begin
      dec.illegal = 1'b0; // compressed words are expanded upstream
    end
    else
    begin
      case (opc)
        OP_LOAD, OP_MISC_MEM, OP_IMM, OP_AUIPC, OP_STORE, OP_OP, OP_LUI,
        OP_BRANCH, OP_JALR, OP_JAL: dec.illegal = 1'b0;
        OP_LOAD_FP, OP_STORE_FP, OP_MADD, OP_MSUB, OP_NMSUB, OP_NMADD,
        OP_FP: dec.illegal = !float_unit_param;
        OP_CUST0, OP_CUST1, OP_CUST2, OP_CUST3:
          dec.illegal = !cust_ok;
        OP_SYSTEM:
        begin
          if (f3 == 3'h0)
          begin
            dec.ecall = (f12 == F12_ECALL);
            dec.brk = (f12 == F12_EBREAK);
            dec.mret = (f12 == F12_MRET);
            dec.illegal = !(dec.ecall || dec.brk || dec.mret);
          end
          else if (f3 == 3'h4)
          begin
            dec.illegal = 1'b1;
          end
          else
          begin
            dec.illegal = csr_fp && !float_unit_param;
          end
        end
        default: dec.illegal = 1'b1;
      endcase
    end
  end
endmodule // tiu_decode

// file: rtl/tiu_trap_unit.sv
// trap and interrupt unit: entry, return, priority and acknowledge
// Operation
// - on trap entry save pc to mepc and global enable to previous
// - every exception jumps to the vector base
// - interrupts jump to base, or base plus four times id if vectored
// - outside debug mode, return jumps to mepc and restores global enable from previous
// - vector base low byte is always zero
// - after reset fetch begins at the boot address input
// - thirty-two level, active high request inputs, no edge detect
// - lines 11, 7, 3 are external, timer, software; 31..16 custom
// - acknowledge is a one-cycle pulse carrying the taken index
// - all interrupts disabled after reset
// - take a line only if global enable, line enable and pending
// - upper sixteen enable and pending bits cover custom lines
// - fixed priority 31..16, then 11, then 3, then 7
// - debug mode ignores all interrupts
// - cause codes 2 illegal, 3 breakpoint, 11 environment call
// - illegal and environment call traps cannot be masked
// - illegal or undefined encodings trap unless enabled as custom
// - without float unit, float ops and float csr access trap
// - without custom and cluster options, custom ops trap
// - trap entry clears the global enable, no hardware nesting
module tiu_trap_unit
  import tiu_pkg::*;
#(
  parameter bit float_unit_param = 1'b0,
  parameter bit custom_ext_param = 1'b0,
  parameter bit cluster_param = 1'b0
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [XLEN-1:0] boot_addr,
  input wire logic [IRQ_W-1:0] irq_req,
  input wire logic debug_mode,
  input wire logic instr_valid,
  input wire logic [XLEN-1:0] instr,
  input wire logic [XLEN-1:0] instr_pc,
  input wire logic sw_status_we,
  input wire tiu_status_t sw_status,
  input wire logic sw_mie_we,
  input wire logic [IRQ_W-1:0] sw_mie,
  input wire logic sw_mtvec_we,
  input wire logic [XLEN-1:0] sw_mtvec,
  input wire logic sw_mepc_we,
  input wire logic [XLEN-1:0] sw_mepc,
  output logic fetch_redirect,
  output logic [XLEN-1:0] fetch_addr,
  output logic irq_ack,
  output logic [ID_W-1:0] irq_taken_index,
  output tiu_status_t status_out,
  output logic [IRQ_W-1:0] mie_out,
  output logic [IRQ_W-1:0] mip_out,
  output logic [XLEN-1:0] mtvec_out,
  output logic [XLEN-1:0] mepc_out,
  output tiu_cause_t mcause_out
);
  typedef enum logic [1:0] {
    TIU_BOOT = 2'b00,
    TIU_RUN = 2'b01
  } tiu_state_t;

  tiu_state_t state_q;
  tiu_status_t status_q;
  tiu_status_t status_d;
  logic [IRQ_W-1:0] mie_q;
  logic [IRQ_W-1:0] mip_q;
  logic [XLEN-1:0] mtvec_q;
  logic [XLEN-1:0] mepc_q;
  tiu_cause_t cause_q;
  logic redirect_q;
  logic [XLEN-1:0] fetch_addr_q;
  logic ack_q;
  logic [ID_W-1:0] ack_id_q;
  tiu_decode_t dec;
  tiu_pick_t pick;
  logic [IRQ_W-1:0] armed;
  logic irq_take;
  logic exc_take;
  logic ret_take;
  logic [CAUSE_W-1:0] exc_code;
  logic [XLEN-1:0] irq_target;

  // enable bits only exist for lines that have a meaning
  function automatic logic [IRQ_W-1:0] used_only(input logic [IRQ_W-1:0] v);
    return v & IRQ_USED_MASK;
  endfunction

  // every check in this block runs on the core clock and sleeps in reset
  default clocking cb_core @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  tiu_decode #(
    .float_unit_param(float_unit_param),
    .custom_ext_param(custom_ext_param),
    .cluster_param(cluster_param)
  ) u_decode (
    .instr(instr),
    .dec(dec)
  );

  // pending reflects the raw level each cycle; the source owns clearing
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mip_q <= '0;
    end
    else
    begin
      mip_q <= used_only(irq_req);
    end
  end

  // debug mode and the global enable gate every line together
  assign armed = (status_q.mie && !debug_mode) ?
                 (mip_q & mie_q) : '0;

  tiu_irq_pick u_pick (
    .req(armed),
    .pick(pick)
  );

  // exceptions go before interrupts on the same instruction; only a valid
  // instruction can raise an exception, and no mask touches illegal or ecall
  assign exc_take = (state_q == TIU_RUN) && instr_valid &&
                    (dec.illegal || dec.brk || dec.ecall);
  assign ret_take = (state_q == TIU_RUN) && instr_valid && !exc_take &&
                    dec.mret && !debug_mode;
  assign irq_take = (state_q == TIU_RUN) && !exc_take && !ret_take &&
                    pick.found && !ack_q;

  // illegal outranks the rest; the three never coincide on one word
  assign exc_code = dec.illegal ? EXC_ILLEGAL :
                    (dec.ecall ? EXC_ECALL : EXC_BREAK);

  // vectored mode offsets by four bytes per id
  always_comb
  begin
    if (mtvec_q[1:0] == MODE_VECTORED)
    begin
      irq_target = (mtvec_q & VEC_BASE_MASK) +
                   XLEN'({pick.id, {VEC_SHIFT{1'b0}}});
    end
    else
    begin
      irq_target = mtvec_q & VEC_BASE_MASK;
    end
  end

  // boot state lasts one cycle so the first redirect is the boot address
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= TIU_BOOT;
    end
    else
    begin
      state_q <= TIU_RUN;
    end
  end

  // status: hardware entry and return win over a software write
  always_comb
  begin
    status_d = status_q;
    if (sw_status_we)
    begin
      status_d = sw_status;
    end
    if (exc_take || irq_take)
    begin
      status_d.mpie = status_q.mie;
      status_d.mie = 1'b0;
    end
    else if (ret_take)
    begin
      status_d.mie = status_q.mpie;
      status_d.mpie = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      status_q <= '0;
    end
    else
    begin
      status_q <= status_d;
    end
  end

  // line enables, cleared at reset
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mie_q <= '0;
    end
    else if (sw_mie_we)
    begin
      mie_q <= used_only(sw_mie);
    end
  end

  // base low byte dropped on write, mode bit 0 kept and mode bit 1 cleared
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mtvec_q <= {30'h0, MODE_DIRECT};
    end
    else if (sw_mtvec_we)
    begin
      mtvec_q <= (sw_mtvec & VEC_BASE_MASK) |
                 {30'h0, sw_mtvec[1:0] & MODE_VECTORED};
    end
  end

  // return address; trap entry takes precedence over a software write
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mepc_q <= '0;
    end
    else if (exc_take || irq_take)
    begin
      mepc_q <= instr_pc;
    end
    else if (sw_mepc_we)
    begin
      mepc_q <= sw_mepc;
    end
  end

  // cause of the last trap taken
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cause_q <= '0;
    end
    else if (exc_take)
    begin
      cause_q <= '{is_irq: 1'b0, code: exc_code};
    end
    else if (irq_take)
    begin
      cause_q <= '{is_irq: 1'b1, code: pick.id};
    end
  end

  // fetch redirect, one pulse per event
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      redirect_q <= 1'b0;
      fetch_addr_q <= '0;
    end
    else if (state_q == TIU_BOOT)
    begin
      redirect_q <= 1'b1;
      fetch_addr_q <= boot_addr;
    end
    else if (exc_take)
    begin
      redirect_q <= 1'b1;
      fetch_addr_q <= mtvec_q & VEC_BASE_MASK;
    end
    else if (irq_take)
    begin
      redirect_q <= 1'b1;
      fetch_addr_q <= irq_target;
    end
    else if (ret_take)
    begin
      redirect_q <= 1'b1;
      fetch_addr_q <= mepc_q;
    end
    else
    begin
      redirect_q <= 1'b0;
    end
  end

  // acknowledge: the index is held after the pulse but means nothing then;
  // a take is blocked in the ack cycle so pulses never merge
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack_q <= 1'b0;
      ack_id_q <= '0;
    end
    else
    begin
      ack_q <= irq_take;
      if (irq_take)
      begin
        ack_id_q <= pick.id;
      end
    end
  end

  assign fetch_redirect = redirect_q;
  assign fetch_addr = fetch_addr_q;
  assign irq_ack = ack_q;
  assign irq_taken_index = ack_id_q;
  assign status_out = status_q;
  assign mie_out = mie_q;
  assign mip_out = mip_q;
  assign mtvec_out = mtvec_q;
  assign mepc_out = mepc_q;
  assign mcause_out = cause_q;

  AST_ACK_ONE: assert property (irq_ack |=> !irq_ack)
    else $error("ack longer than one cycle");

  AST_ACK_CAUSE: assert property (
    irq_ack |-> mcause_out.is_irq && (mcause_out.code == irq_taken_index))
    else $error("ack index differs from cause");

  AST_ENTRY_MIE: assert property (
    (irq_take || exc_take) |=>
      !status_out.mie && (status_out.mpie == $past(status_q.mie)))
    else $error("entry did not stack enable");

  AST_EPC: assert property (
    (irq_take || exc_take) |=> mepc_out == $past(instr_pc))
    else $error("mepc not saved");

  AST_DEBUG: assert property (debug_mode |-> !irq_take)
    else $error("interrupt taken in debug mode");

  AST_EXC_VEC: assert property (
    exc_take |=> fetch_redirect &&
      (fetch_addr == ($past(mtvec_q) & VEC_BASE_MASK)))
    else $error("exception vector wrong");

  AST_RET: assert property (
    ret_take |=> (fetch_addr == $past(mepc_q)) &&
      (status_out.mie == $past(status_q.mpie)))
    else $error("return wrong");

  AST_ALIGN: assert property (mtvec_out[7:2] == 6'h00)
    else $error("vector base not aligned");

  AST_GATE: assert property (
    irq_take |-> status_q.mie && mie_q[pick.id] && mip_q[pick.id])
    else $error("interrupt taken while not armed");

  AST_BOOT: assert property (
    $rose(state_q == TIU_RUN) |->
      fetch_redirect && (fetch_addr == $past(boot_addr)))
    else $error("boot fetch address wrong");
endmodule // tiu_trap_unit

// file: sim/tiu_irq_src.sv
// interrupt source model: level requests cleared by completion or ack
module tiu_irq_src
  import tiu_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [IRQ_W-1:0] set_lines,
  input wire logic [IRQ_W-1:0] clr_lines,
  input wire logic irq_ack,
  input wire logic [ID_W-1:0] irq_taken_index,
  output logic [IRQ_W-1:0] irq_req
);
  logic [IRQ_W-1:0] lvl_q;
  // a line stays high until software completion or its own ack is seen
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lvl_q <= '0;
    end
    else
    begin
      lvl_q <= (lvl_q | set_lines) & ~clr_lines;
      if (irq_ack)
      begin
        lvl_q[irq_taken_index] <= 1'b0;
      end
    end
  end
  // reserved lines never leave zero, whatever the bench asks for
  assign irq_req = lvl_q & IRQ_USED_MASK;
endmodule // tiu_irq_src

// file: sim/tb.sv
// self-checking bench for the trap and interrupt unit
module tb
  import tiu_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [31:0] PC = 32'h0000_2000;
  logic clk, rst_n, debug_mode, instr_valid, fetch_redirect, irq_ack;
  logic sw_status_we, sw_mie_we, sw_mtvec_we, sw_mepc_we;
  logic [31:0] boot_addr, instr, instr_pc, sw_mie, sw_mtvec, sw_mepc;
  logic [31:0] set_lines, clr_lines, irq_req, fetch_addr;
  logic [31:0] mie_out, mip_out, mtvec_out, mepc_out;
  logic [4:0] irq_taken_index;
  tiu_status_t sw_status, status_out;
  tiu_cause_t mcause_out;
  int error_cnt, comparisons;

  tiu_trap_unit DUT (.clk(clk), .rst_n(rst_n), .boot_addr(boot_addr),
    .irq_req(irq_req), .debug_mode(debug_mode), .instr_valid(instr_valid),
    .instr(instr), .instr_pc(instr_pc), .sw_status_we(sw_status_we),
    .sw_status(sw_status), .sw_mie_we(sw_mie_we), .sw_mie(sw_mie),
    .sw_mtvec_we(sw_mtvec_we), .sw_mtvec(sw_mtvec), .sw_mepc_we(sw_mepc_we),
    .sw_mepc(sw_mepc), .fetch_redirect(fetch_redirect),
    .fetch_addr(fetch_addr), .irq_ack(irq_ack),
    .irq_taken_index(irq_taken_index), .status_out(status_out),
    .mie_out(mie_out), .mip_out(mip_out), .mtvec_out(mtvec_out),
    .mepc_out(mepc_out), .mcause_out(mcause_out));
  tiu_irq_src src (.clk(clk), .rst_n(rst_n), .set_lines(set_lines),
    .clr_lines(clr_lines), .irq_ack(irq_ack),
    .irq_taken_index(irq_taken_index), .irq_req(irq_req));

  // free-running core clock
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
    input string what);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // software write: 0 status, 1 mie, 2 mtvec, 3 mepc
  task automatic wr(input int which, input logic [31:0] v);
    @(posedge clk);
    sw_status_we <= (which == 0);
    sw_mie_we <= (which == 1);
    sw_mtvec_we <= (which == 2);
    sw_mepc_we <= (which == 3);
    sw_status <= v[1:0];
    sw_mie <= v;
    sw_mtvec <= v;
    sw_mepc <= v;
    @(posedge clk);
    {sw_status_we, sw_mie_we, sw_mtvec_we, sw_mepc_we} <= 4'h0;
    #1;
  endtask

  // set_lines pulses for one cycle and the source holds the level; mip follows one edge later
  task automatic raise(input logic [31:0] m);
    @(posedge clk);
    set_lines <= m;
    @(posedge clk);
    set_lines <= 32'h0000_0000;
    #1;
  endtask

  task automatic exec(input logic [31:0] w);
    @(posedge clk);
    instr_valid <= 1'b1;
    instr <= w;
    @(posedge clk);
    instr_valid <= 1'b0;
    #1;
    chk(fetch_redirect, 32'h1, "redirect");
  endtask

  task automatic no_ack(input int n);
    repeat (n)
    begin
      @(posedge clk);
      #1;
      chk(irq_ack, 32'h0, "unexpected ack");
    end
  endtask

  // bounded wait for ack, then judge entry state and pulse width
  task automatic take_irq(input logic [4:0] id, input logic [31:0] addr);
    bit got;
    got = 0;
    for (int i = 0; i < 20 && !got; i++)
    begin
      @(posedge clk);
      #1;
      got = (irq_ack === 1'b1);
    end
    if (!got)
    begin
      error_cnt++;
      $display("[FAIL] %0t no ack for line %0d", $time, id);
      report_and_stop();
    end
    else
    begin
      chk(irq_taken_index, id, "index");
      chk(fetch_redirect, 32'h1, "irq redirect");
      chk(fetch_addr, addr, "irq vector");
      chk(mcause_out, {1'b1, id}, "irq cause");
      chk(status_out, 32'h1, "entry status");
      chk(mepc_out, PC, "irq mepc");
      @(posedge clk);
      #1;
      chk(irq_ack, 32'h0, "ack width");
      chk(fetch_redirect, 32'h0, "redirect width");
    end
  endtask

  task automatic t_reset();
    for (int i = 0; i < 4 && fetch_redirect !== 1'b1; i++)
    begin
      @(posedge clk);
      #1;
    end
    if (fetch_redirect !== 1'b1)
    begin
      error_cnt++;
      $display("[FAIL] %0t no boot redirect", $time);
      report_and_stop();
    end
    else
    begin
      chk(fetch_addr, boot_addr, "boot fetch");
      chk(status_out, 32'h0, "reset status");
      chk(mie_out, 32'h0, "reset mie");
    end
    $display("test reset done");
  endtask

  task automatic t_direct();
    wr(2, 32'h0000_34FC);
    chk(mtvec_out, 32'h0000_3400, "mtvec low byte");
    wr(1, 32'h0000_0800);
    wr(0, 32'h2);
    raise(32'h0000_0800);
    take_irq(5'h0B, 32'h0000_3400);
    $display("test direct done");
  endtask

  task automatic t_prio();
    logic [4:0] ids [5] = '{5'h1F, 5'h10, 5'h0B, 5'h03, 5'h07};
    wr(2, 32'h0000_5601);
    wr(1, 32'hFFFF_FFFF);
    chk(mie_out, 32'hFFFF_0888, "mie used bits");
    wr(1, 32'h8001_0888);
    raise(32'h8001_1888);
    // the level is registered once more before it shows as pending
    @(posedge clk);
    #1;
    chk(mip_out, 32'h8001_0888, "pending lines");
    foreach (ids[i])
    begin
      wr(0, 32'h2);
      take_irq(ids[i], 32'h0000_5600 + {ids[i], 2'b00});
    end
    $display("test priority done");
  endtask

  task automatic t_masked();
    raise(32'h0000_0800);
    no_ack(10);
    @(posedge clk);
    debug_mode <= 1'b1;
    wr(0, 32'h2);
    no_ack(10);
    @(posedge clk);
    debug_mode <= 1'b0;
    take_irq(5'h0B, 32'h0000_562C);
    $display("test masked done");
  endtask

  task automatic t_exc();
    logic [31:0] w [6] = '{32'hFFFF_FFFF, 32'h0000_0053, 32'h0010_2073,
      32'h0000_000B, 32'h0010_0073, 32'h0000_0073};
    logic [4:0] c [6] = '{5'h02, 5'h02, 5'h02, 5'h02, 5'h03, 5'h0B};
    foreach (w[i])
    begin
      exec(w[i]);
      chk(fetch_addr, 32'h0000_5600, "exc vector");
      chk(mcause_out, {1'b0, c[i]}, "exc cause");
      chk(mepc_out, PC, "exc mepc");
    end
    $display("test exceptions done");
  endtask

  task automatic t_mret();
    wr(3, 32'h0000_ABC0);
    wr(0, 32'h1);
    exec(32'h3020_0073);
    chk(fetch_addr, 32'h0000_ABC0, "return address");
    chk(status_out, 32'h3, "restored enable");
    $display("test return done");
  endtask

  // main sequence: reset held two cycles, then each scenario in turn
  initial
  begin
    error_cnt = 0;
    comparisons = 0;
    rst_n = 1'b0;
    boot_addr = 32'h0000_0180;
    {debug_mode, instr_valid} = 2'h0;
    {sw_status_we, sw_mie_we, sw_mtvec_we, sw_mepc_we} = 4'h0;
    sw_status = 2'h0;
    {sw_mie, sw_mtvec, sw_mepc} = '0;
    instr = 32'h0000_0013;
    instr_pc = PC;
    set_lines = 32'h0000_0000;
    clr_lines = 32'h0000_0000;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_direct();
    t_prio();
    t_masked();
    t_exc();
    t_mret();
    report_and_stop();
  end
endmodule // tb
